// ==== pkg/cfte_pkg.sv ====
// constants and types shared by the chunked file transfer engine
package cfte_pkg;
    // register byte offsets on the axi4-lite slave
    localparam logic [11:0] OFF_FILE_CHOICE = 12'h000;
    localparam logic [11:0] OFF_OPEN_DIRECTION = 12'h004;
    localparam logic [11:0] OFF_OPERATION_CHOICE = 12'h008;
    localparam logic [11:0] OFF_OPERATION_TRIGGER = 12'h00c;
    localparam logic [11:0] OFF_OPERATION_OUTCOME = 12'h010;
    localparam logic [11:0] OFF_FILE_BYTE_TOTAL = 12'h014;
    localparam logic [11:0] OFF_WINDOW_POSITION = 12'h018;
    localparam logic [11:0] OFF_CHUNK_BYTE_COUNT = 12'h01c;
    localparam logic [11:0] OFF_BYTES_MOVED = 12'h020;
    localparam logic [11:0] OFF_WINDOW_LENGTH = 12'h024;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h028;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h02c;
    // transfer window sits at 0x400, one byte lane per address byte
    localparam logic [1:0] WINDOW_PAGE = 2'h1;
    localparam logic [31:0] WINDOW_BYTES = 32'h0000_03dc;
    localparam logic [7:0] WINDOW_WORDS = 8'hf7;
    // field positions
    localparam int FILE_CHOICE_W = 4;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_FAIL_BIT = 1;
    // values after reset
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] RST_IRQ = 2'h0;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // storage port request kinds
    localparam logic [1:0] STORE_RD_BYTE = 2'h0;
    localparam logic [1:0] STORE_WR_BYTE = 2'h1;
    localparam logic [1:0] STORE_SIZE = 2'h2;

    typedef enum logic [1:0] {
        OP_OPEN = 2'b00,
        OP_CLOSE = 2'b01,
        OP_READ = 2'b10,
        OP_WRITE = 2'b11
    } cfte_op_t;

    typedef enum logic [3:0] {
        OUT_SUCCESS = 4'h0,
        OUT_BAD_ARGUMENT = 4'h1,
        OUT_READ_ONLY = 4'h2,
        OUT_UNOPENED = 4'h3,
        OUT_OVERSIZE = 4'h4,
        OUT_ABSENT_FILE = 4'h5
    } cfte_outcome_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CHECK = 3'b001,
        ST_SIZE_WAIT = 3'b010,
        ST_RD_REQ = 3'b011,
        ST_WR_FETCH = 3'b100,
        ST_WR_LOAD = 3'b101,
        ST_WR_REQ = 3'b110,
        ST_DONE = 3'b111
    } cfte_state_t;
endpackage : cfte_pkg

// ==== pkg/cfte_mem_if.sv ====
// carrier between the engine and its transfer window memory
`timescale 1ns/1ps
interface cfte_mem_if;
    logic [7:0] a_raddr;
    logic [7:0] a_waddr;
    logic [3:0] a_we;
    logic [31:0] a_wdata;
    logic [31:0] a_rdata;
    logic [9:0] b_addr;
    logic b_we;
    logic [7:0] b_wdata;
    logic [7:0] b_rdata;

    modport eng (
        output a_raddr, a_waddr, a_we, a_wdata, b_addr, b_we, b_wdata,
        input a_rdata, b_rdata
    );
    modport mem (
        input a_raddr, a_waddr, a_we, a_wdata, b_addr, b_we, b_wdata,
        output a_rdata, b_rdata
    );
endinterface : cfte_mem_if

// ==== verilog/cfte_window_mem.sv ====
// transfer window memory: word port for the bus, byte port for the engine
`timescale 1ns/1ps
module cfte_window_mem
    import cfte_pkg::*;
(
    input wire logic aclk,
    input wire logic ce,
    cfte_mem_if.mem port
);
    logic [7:0] b_lane_q [4];
    logic [1:0] b_lane_ff;

    // four byte lanes, registered read data on both ports
    for (genvar k = 0; k < 4; k++) begin : g_lane
        logic [7:0] ram [0:WINDOW_WORDS-1];
        logic [7:0] a_q;
        logic [7:0] b_q;
        always_ff @(posedge aclk) begin
            if (ce) begin
                if (port.a_we[k])
                    ram[port.a_waddr] <= port.a_wdata[8*k +: 8];
                if (port.b_we && port.b_addr[1:0] == 2'(k))
                    ram[port.b_addr[9:2]] <= port.b_wdata;
                a_q <= ram[port.a_raddr];
                b_q <= ram[port.b_addr[9:2]];
            end
        end
        assign port.a_rdata[8*k +: 8] = a_q;
        assign b_lane_q[k] = b_q;
    end

    // lane of the byte read remembered with its data
    always_ff @(posedge aclk) begin
        if (ce)
            b_lane_ff <= port.b_addr[1:0];
    end

    assign port.b_rdata = b_lane_q[b_lane_ff];
endmodule : cfte_window_mem

// ==== verilog/cfte_engine.sv ====
// chunked file transfer engine with axi4-lite registers and window
`timescale 1ns/1ps
// How it works
// - trigger reads back; 1 starts the operation, hardware clears it when done
// - outcome code after each operation: 0 success, else a specific failure
// - opened for reading, file byte total holds the real file length
// - window holds 988 bytes per chunk and reports that capacity
// - read copies count bytes from storage at position into the window
// - bytes moved per chunk reported; host advances offset by it
// - failures: bad argument, read only, unopened, oversize, absent file
// - bytes moved is read only, counts bytes of the latest operation
module cfte_engine
    import cfte_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] file_present,
    input wire logic [15:0] file_writable,
    output logic store_req,
    output logic [1:0] store_op,
    output logic [cfte_pkg::FILE_CHOICE_W-1:0] store_file,
    output logic [31:0] store_addr,
    output logic [7:0] store_wdata,
    input wire logic store_ack,
    input wire logic [31:0] store_rdata,
    output logic irq
);
    import cfte_pkg::*;

    cfte_mem_if win ();

    // bus slave state
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, rd_wait_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [11:0] aw_addr_ff, ar_addr_ff;
    logic [31:0] w_data_ff, rdata_ff;
    logic [3:0] w_strb_ff;
    // feature registers
    logic [FILE_CHOICE_W-1:0] file_choice_ff;
    logic open_direction_ff;
    cfte_op_t operation_choice_ff;
    logic operation_trigger_ff;
    cfte_outcome_t operation_outcome_ff;
    logic [31:0] file_byte_total_ff, window_position_ff, chunk_byte_count_ff, bytes_moved_ff;
    logic [1:0] irq_status_ff, irq_mask_ff;
    logic irq_ff;
    // engine state
    cfte_state_t state_ff;
    logic open_ff, open_dir_ff;
    logic [FILE_CHOICE_W-1:0] open_file_ff;
    logic [9:0] cnt_ff;
    logic store_req_ff;
    logic [1:0] store_op_ff;
    logic [31:0] store_addr_ff;
    logic [7:0] store_wdata_ff;

    // byte-strobe merge for a register write
    function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                res[8*i +: 8] = nw[8*i +: 8];
        return res;
    endfunction : merge_strb

    // true when a byte address falls inside the transfer window
    function automatic logic win_hit(input logic [11:0] addr);
        return (addr[11:10] == WINDOW_PAGE) && (addr[9:2] < WINDOW_WORDS);
    endfunction : win_hit

    // write channel decode
    wire busy = (state_ff != ST_IDLE);
    wire wr_go = !awready_ff && !wready_ff && !bvalid_ff;
    wire wr_en = wr_go && ce;
    wire wr_is_win = win_hit(aw_addr_ff);
    wire [11:0] wa = {aw_addr_ff[11:2], 2'b00};
    wire wr_known = wr_is_win || (wa <= OFF_IRQ_MASK);
    wire wr_cfg = wr_en && !busy;
    wire trig_start = wr_cfg && wa == OFF_OPERATION_TRIGGER && w_strb_ff[0] && w_data_ff[0];
    wire [1:0] irq_clr = (wr_en && wa == OFF_IRQ_STATUS && w_strb_ff[0]) ? w_data_ff[1:0] : 2'h0;

    // read channel decode
    wire rd_take = s_axi_arvalid && arready_ff;
    wire [11:0] ra = {ar_addr_ff[11:2], 2'b00};
    wire rd_is_win = win_hit(ar_addr_ff);
    logic [31:0] rd_mux;
    logic rd_known;
    always_comb begin
        rd_known = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (ra)
            OFF_FILE_CHOICE: rd_mux = 32'(file_choice_ff);
            OFF_OPEN_DIRECTION: rd_mux = 32'(open_direction_ff);
            OFF_OPERATION_CHOICE: rd_mux = 32'(operation_choice_ff);
            OFF_OPERATION_TRIGGER: rd_mux = 32'(operation_trigger_ff);
            OFF_OPERATION_OUTCOME: rd_mux = 32'(operation_outcome_ff);
            OFF_FILE_BYTE_TOTAL: rd_mux = file_byte_total_ff;
            OFF_WINDOW_POSITION: rd_mux = window_position_ff;
            OFF_CHUNK_BYTE_COUNT: rd_mux = chunk_byte_count_ff;
            OFF_BYTES_MOVED: rd_mux = bytes_moved_ff;
            OFF_WINDOW_LENGTH: rd_mux = WINDOW_BYTES;
            OFF_IRQ_STATUS: rd_mux = 32'(irq_status_ff);
            OFF_IRQ_MASK: rd_mux = 32'(irq_mask_ff);
            default: begin
                rd_known = rd_is_win;
                rd_mux = rd_is_win ? win.a_rdata : 32'h0000_0000;
            end
        endcase
    end

    // window memory hookup; bus writes only while idle
    assign win.a_raddr = arready_ff ? s_axi_araddr[9:2] : ar_addr_ff[9:2];
    assign win.a_waddr = aw_addr_ff[9:2];
    assign win.a_we = (wr_cfg && wr_is_win) ? w_strb_ff : 4'h0;
    assign win.a_wdata = w_data_ff;
    assign win.b_addr = cnt_ff;
    assign win.b_we = ce && state_ff == ST_RD_REQ && store_ack;
    assign win.b_wdata = store_rdata[7:0];

    cfte_window_mem u_mem (
        .aclk(aclk),
        .ce(ce),
        .port(win.mem)
    );

    // operation checks
    wire [31:0] cnt_ext = {22'h000000, cnt_ff};
    wire sel_open = open_ff && open_file_ff == file_choice_ff;
    wire len_bad = chunk_byte_count_ff == 32'h0 || chunk_byte_count_ff > WINDOW_BYTES;
    wire span_big = ({1'b0, window_position_ff} + {1'b0, chunk_byte_count_ff})
                    > {1'b0, file_byte_total_ff};
    wire last_byte = (cnt_ext + 32'h1) == chunk_byte_count_ff;
    cfte_outcome_t chk;
    always_comb begin
        chk = OUT_SUCCESS;
        unique case (operation_choice_ff)
            OP_OPEN: begin
                if (!file_present[file_choice_ff])
                    chk = OUT_ABSENT_FILE;
                else if (open_ff)
                    chk = OUT_BAD_ARGUMENT;
                else if (open_direction_ff && !file_writable[file_choice_ff])
                    chk = OUT_READ_ONLY;
            end
            OP_CLOSE: begin
                if (!sel_open)
                    chk = OUT_UNOPENED;
            end
            OP_READ: begin
                if (!sel_open)
                    chk = OUT_UNOPENED;
                else if (open_dir_ff || len_bad)
                    chk = OUT_BAD_ARGUMENT;
                else if (span_big)
                    chk = OUT_OVERSIZE;
            end
            OP_WRITE: begin
                if (!sel_open)
                    chk = OUT_UNOPENED;
                else if (!open_dir_ff)
                    chk = OUT_READ_ONLY;
                else if (len_bad)
                    chk = OUT_BAD_ARGUMENT;
                else if (span_big)
                    chk = OUT_OVERSIZE;
            end
        endcase
    end

    // write address and data channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            aw_addr_ff <= 12'h000;
            w_data_ff <= RST_WORD;
            w_strb_ff <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && awready_ff) begin
                aw_addr_ff <= s_axi_awaddr;
                awready_ff <= 1'b0;
            end
            if (s_axi_wvalid && wready_ff) begin
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
                wready_ff <= 1'b0;
            end
            if (wr_go) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // read channel, answer two edges after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rd_wait_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= RST_WORD;
            ar_addr_ff <= 12'h000;
        end else if (ce) begin
            rd_wait_ff <= rd_take;
            if (rd_take) begin
                ar_addr_ff <= s_axi_araddr;
                arready_ff <= 1'b0;
            end
            if (rd_wait_ff) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_mux;
                rresp_ff <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    // host-written configuration, frozen while an operation runs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            file_choice_ff <= '0;
            open_direction_ff <= 1'b0;
            operation_choice_ff <= OP_OPEN;
            window_position_ff <= RST_WORD;
            chunk_byte_count_ff <= RST_WORD;
            irq_mask_ff <= RST_IRQ;
        end else if (wr_cfg && w_strb_ff[0]) begin
            if (wa == OFF_FILE_CHOICE)
                file_choice_ff <= w_data_ff[FILE_CHOICE_W-1:0];
            if (wa == OFF_OPEN_DIRECTION)
                open_direction_ff <= w_data_ff[0];
            if (wa == OFF_OPERATION_CHOICE)
                operation_choice_ff <= cfte_op_t'(w_data_ff[1:0]);
            if (wa == OFF_IRQ_MASK)
                irq_mask_ff <= w_data_ff[1:0];
        end
        if (aresetn && wr_cfg && wa == OFF_WINDOW_POSITION)
            window_position_ff <= merge_strb(window_position_ff, w_data_ff, w_strb_ff);
        if (aresetn && wr_cfg && wa == OFF_CHUNK_BYTE_COUNT)
            chunk_byte_count_ff <= merge_strb(chunk_byte_count_ff, w_data_ff, w_strb_ff);
    end

    // trigger: set by host write, cleared by the engine when finished
    always_ff @(posedge aclk) begin
        if (!aresetn)
            operation_trigger_ff <= 1'b0;
        else if (ce) begin
            if (trig_start)
                operation_trigger_ff <= 1'b1;
            else if (state_ff == ST_DONE)
                operation_trigger_ff <= 1'b0;
        end
    end

    // operation sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_IDLE;
            open_ff <= 1'b0;
            open_dir_ff <= 1'b0;
            open_file_ff <= '0;
            cnt_ff <= 10'h000;
            operation_outcome_ff <= OUT_SUCCESS;
            file_byte_total_ff <= RST_WORD;
            bytes_moved_ff <= RST_WORD;
            store_req_ff <= 1'b0;
            store_op_ff <= STORE_RD_BYTE;
            store_addr_ff <= RST_WORD;
            store_wdata_ff <= 8'h00;
        end else if (ce) begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (trig_start)
                        state_ff <= ST_CHECK;
                end
                ST_CHECK: begin
                    cnt_ff <= 10'h000;
                    bytes_moved_ff <= RST_WORD;
                    store_addr_ff <= window_position_ff;
                    if (chk != OUT_SUCCESS) begin
                        operation_outcome_ff <= chk;
                        state_ff <= ST_DONE;
                    end else begin
                        operation_outcome_ff <= OUT_SUCCESS;
                        unique case (operation_choice_ff)
                            OP_OPEN: begin
                                open_file_ff <= file_choice_ff;
                                open_dir_ff <= open_direction_ff;
                                store_op_ff <= STORE_SIZE;
                                store_req_ff <= 1'b1;
                                state_ff <= ST_SIZE_WAIT;
                            end
                            OP_CLOSE: begin
                                open_ff <= 1'b0;
                                state_ff <= ST_DONE;
                            end
                            OP_READ: begin
                                store_op_ff <= STORE_RD_BYTE;
                                store_req_ff <= 1'b1;
                                state_ff <= ST_RD_REQ;
                            end
                            OP_WRITE: begin
                                store_op_ff <= STORE_WR_BYTE;
                                state_ff <= ST_WR_FETCH;
                            end
                        endcase
                    end
                end
                ST_SIZE_WAIT: begin
                    if (store_ack) begin
                        file_byte_total_ff <= store_rdata;
                        open_ff <= 1'b1;
                        store_req_ff <= 1'b0;
                        state_ff <= ST_DONE;
                    end
                end
                ST_RD_REQ: begin
                    if (store_ack) begin
                        bytes_moved_ff <= bytes_moved_ff + 32'h1;
                        cnt_ff <= cnt_ff + 10'h001;
                        store_addr_ff <= store_addr_ff + 32'h1;
                        if (last_byte) begin
                            store_req_ff <= 1'b0;
                            state_ff <= ST_DONE;
                        end
                    end
                end
                ST_WR_FETCH: state_ff <= ST_WR_LOAD;
                ST_WR_LOAD: begin
                    store_wdata_ff <= win.b_rdata;
                    store_req_ff <= 1'b1;
                    state_ff <= ST_WR_REQ;
                end
                ST_WR_REQ: begin
                    if (store_ack) begin
                        store_req_ff <= 1'b0;
                        bytes_moved_ff <= bytes_moved_ff + 32'h1;
                        cnt_ff <= cnt_ff + 10'h001;
                        store_addr_ff <= store_addr_ff + 32'h1;
                        state_ff <= last_byte ? ST_DONE : ST_WR_FETCH;
                    end
                end
                ST_DONE: state_ff <= ST_IDLE;
            endcase
        end
    end

    // sticky interrupt status, set wins over write-one-to-clear
    wire op_end = ce && state_ff == ST_DONE;
    wire [1:0] irq_set = op_end ? {operation_outcome_ff != OUT_SUCCESS, 1'b1} : 2'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_ff <= RST_IRQ;
            irq_ff <= 1'b0;
        end else if (ce) begin
            irq_status_ff <= (irq_status_ff & ~irq_clr) | irq_set;
            irq_ff <= |(irq_status_ff & irq_mask_ff);
        end
    end

    // outputs
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign store_req = store_req_ff;
    assign store_op = store_op_ff;
    assign store_file = open_file_ff;
    assign store_addr = store_addr_ff;
    assign store_wdata = store_wdata_ff;
    assign irq = irq_ff;
endmodule : cfte_engine

// ==== test/cfte_sva.sv ====
// port assertions for the file transfer engine
`timescale 1ns/1ps
module cfte_sva
    import cfte_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic store_req,
    input wire logic [1:0] store_op,
    input wire logic [31:0] store_addr,
    input wire logic store_ack
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // bus answers and their holding
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
        else $error("read latency");
    a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write latency");
    a_write_closed: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write slot open");
    a_read_closed: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read slot open");
    // storage requests
    a_store_holds: assert property (store_req && !store_ack |=> store_req && $stable(store_addr))
        else $error("store request moved");
    a_byte_order: assert property (store_req && store_ack && store_op == STORE_RD_BYTE ##1 store_req
        |-> store_addr == $past(store_addr) + 32'h1) else $error("bytes out of order");
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_rd_byte: cover property (store_ack && store_op == STORE_RD_BYTE);
    c_wr_byte: cover property (store_ack && store_op == STORE_WR_BYTE);
endmodule : cfte_sva
bind cfte_engine cfte_sva cfte_sva_inst (.*);

// ==== test/cfte_store_model.sv ====
// file storage model behind the engine's storage port
`timescale 1ns/1ps
module cfte_store_model
    import cfte_pkg::*;
(
    input wire logic aclk,
    input wire logic store_req,
    input wire logic [1:0] store_op,
    input wire logic [3:0] store_file,
    input wire logic [31:0] store_addr,
    input wire logic [7:0] store_wdata,
    output logic store_ack,
    output logic [31:0] store_rdata
);
    logic [7:0] mem_ff [0:1023];
    logic [1:0] wait_ff = 2'h0;
    initial store_ack = 1'b0;
    initial store_rdata = 32'h0;
    initial for (int i = 0; i < 1024; i++) mem_ff[i] = 8'(i);
    // ack after 0..3 waits; junk data otherwise
    always @(posedge aclk) begin
        store_ack <= 1'b0;
        store_rdata <= ~store_rdata;
        wait_ff <= 2'h0;
        if (store_req && !store_ack) begin
            wait_ff <= wait_ff + 2'h1;
            if (wait_ff == store_addr[1:0]) begin
                store_ack <= 1'b1;
                if (store_op == STORE_WR_BYTE) mem_ff[{store_file, store_addr[5:0]}] <= store_wdata;
                store_rdata <= (store_op == STORE_SIZE) ? {28'h0, store_file} + 32'h8
                    : {24'h0, mem_ff[{store_file, store_addr[5:0]}]};
            end
        end
    end
endmodule : cfte_store_model

// ==== test/cfte_engine_test.sv ====
// self-checking bench for the file transfer engine
`timescale 1ns/1ps
module cfte_engine_test;
    import cfte_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, store_addr, store_rdata, got;
    logic [15:0] file_present = 16'h0007, file_writable = 16'h0002;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic irq, store_req, store_ack;
    logic [1:0] s_axi_bresp, s_axi_rresp, store_op, resp;
    logic [3:0] store_file;
    logic [7:0] store_wdata;
    int fail_count = 0, compares = 0, cycles = 0;
    always #5 aclk = ~aclk;
    cfte_engine cfte_engine_inst (.ce(1'b1), .s_axi_wstrb(4'hf), .*);
    cfte_store_model cfte_store_model_inst (.*);
    // bus write and read
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        got = s_axi_rdata;
        resp = s_axi_rresp;
    endtask : rd
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // fire, poll, check outcome
    task automatic op(input cfte_op_t c, input cfte_outcome_t oc, input bit busy);
        wr(OFF_OPERATION_CHOICE, {30'h0, c});
        wr(OFF_OPERATION_TRIGGER, 32'h1);
        rd(OFF_OPERATION_TRIGGER);
        if (busy) chk("busy trigger", 32'h1, got);
        while (got !== 32'h0) rd(OFF_OPERATION_TRIGGER);
        chk("trigger", 32'h0, got);
        rd(OFF_OPERATION_OUTCOME);
        chk("outcome", {28'h0, oc}, got);
    endtask : op
    task automatic t_basics();
        rd(OFF_WINDOW_LENGTH);
        chk("window length", 32'd988, got);
        rd(12'h0fc);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        wr(OFF_BYTES_MOVED, 32'h5);
        rd(OFF_BYTES_MOVED);
        chk("moved ro", 32'h0, got);
    endtask : t_basics
    task automatic t_read();
        wr(OFF_FILE_CHOICE, 32'h2);
        wr(OFF_OPEN_DIRECTION, 32'h0);
        op(OP_OPEN, OUT_SUCCESS, 0);
        rd(OFF_FILE_BYTE_TOTAL);
        chk("total", 32'd10, got);
        wr(OFF_WINDOW_POSITION, 32'h3);
        wr(OFF_CHUNK_BYTE_COUNT, 32'h4);
        op(OP_READ, OUT_SUCCESS, 1);
        rd(OFF_BYTES_MOVED);
        chk("moved", 32'h4, got);
        rd(12'h400);
        chk("window", 32'h86858483, got);
    endtask : t_read
    task automatic t_errors();
        wr(OFF_CHUNK_BYTE_COUNT, 32'd989);
        op(OP_READ, OUT_BAD_ARGUMENT, 0);
        wr(OFF_CHUNK_BYTE_COUNT, 32'h8);
        op(OP_READ, OUT_OVERSIZE, 0);
        rd(OFF_BYTES_MOVED);
        chk("moved on error", 32'h0, got);
        op(OP_WRITE, OUT_READ_ONLY, 0);
        op(OP_CLOSE, OUT_SUCCESS, 0);
        op(OP_CLOSE, OUT_UNOPENED, 0);
        wr(OFF_FILE_CHOICE, 32'h5);
        op(OP_OPEN, OUT_ABSENT_FILE, 0);
    endtask : t_errors
    task automatic t_write();
        wr(OFF_IRQ_MASK, 32'h3);
        wr(OFF_FILE_CHOICE, 32'h2);
        wr(OFF_OPEN_DIRECTION, 32'h1);
        op(OP_OPEN, OUT_READ_ONLY, 0);
        wr(OFF_IRQ_STATUS, 32'h3);
        wr(OFF_FILE_CHOICE, 32'h1);
        op(OP_OPEN, OUT_SUCCESS, 0);
        chk("irq raised", 32'h1, {31'h0, irq});
        rd(OFF_FILE_BYTE_TOTAL);
        chk("limit", 32'd9, got);
        wr(12'h400, 32'hd4c3b2a1);
        wr(OFF_WINDOW_POSITION, 32'h2);
        wr(OFF_CHUNK_BYTE_COUNT, 32'h4);
        op(OP_WRITE, OUT_SUCCESS, 0);
        rd(OFF_BYTES_MOVED);
        chk("moved", 32'h4, got);
        chk("stored", 32'hd4c3b2a1, {cfte_store_model_inst.mem_ff[69],
            cfte_store_model_inst.mem_ff[68], cfte_store_model_inst.mem_ff[67],
            cfte_store_model_inst.mem_ff[66]});
        wr(OFF_IRQ_STATUS, 32'h3);
        wr(OFF_IRQ_MASK, 32'h0);
        op(OP_CLOSE, OUT_SUCCESS, 0);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd(OFF_IRQ_STATUS);
        chk("irq status", 32'h1, got);
    endtask : t_write
    task automatic stop_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    // main sequence after two reset cycles
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_basics();
        t_read();
        t_errors();
        t_write();
        stop_test();
    end
    // hang guard
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end
endmodule : cfte_engine_test
